// *** dv/lms_chk.sv ***
`timescale 1ns/10ps
// ********************
// Sequencer checker
// ********************
module lms_chk #(
    parameter MS_CYCLES = 2
) (
    input wire REF_CLK,
    input wire RST,
    input wire RD,
    input wire [15:0] RDATA,
    input wire LIFT_CMD,
    input wire DROP_CMD,
    input wire [15:0] FAULT_COND,
    input wire [15:0] CURRENT_REF,
    input wire [2:0] PHASE,
    input wire FAULT_ACTIVE
);
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RST);

    // Latched fault must hold the magnet at zero
    fault_zero_ref_a: assert property (FAULT_ACTIVE [*3] |-> CURRENT_REF == 16'h0000 && PHASE == 3'h0)
        else $error("reference not zero during fault");
    // A live condition latches within two edges
    fault_latch_a: assert property ((|FAULT_COND[9:0]) |-> ##[1:2] FAULT_ACTIVE)
        else $error("fault condition not latched");
    // Lift only starts on a lift command
    lift_start_a: assert property (PHASE == 3'h1 && $past(PHASE) == 3'h0 |-> $past(LIFT_CMD, 2))
        else $error("lift phase without lift command");
    // Hold only follows lift
    hold_entry_a: assert property (PHASE == 3'h2 && $past(PHASE) != 3'h2 |-> $past(PHASE) == 3'h1)
        else $error("hold entered from wrong phase");
    // Hold keeps the reference steady while no fault is active
    hold_steady_a: assert property (PHASE == 3'h2 && $past(PHASE) == 3'h2 && !FAULT_ACTIVE
        |-> $stable(CURRENT_REF))
        else $error("hold reference moved");
    // Dribble never raises the reference
    dribble_down_a: assert property (PHASE == 3'h3 && $past(PHASE) == 3'h3
        |-> $signed(CURRENT_REF) <= $signed($past(CURRENT_REF)))
        else $error("dribble reference rose");
    drop_cause_a: assert property (PHASE == 3'h4 && $past(PHASE) != 3'h4
        |-> !$past(LIFT_CMD, 2) || $past(DROP_CMD, 2))
        else $error("drop entered without cause");
    drop_steady_a: assert property (PHASE == 3'h4 && $past(PHASE) == 3'h4 && !FAULT_ACTIVE
        |-> $stable(CURRENT_REF))
        else $error("clean reference moved");
    zero_ref_a: assert property (PHASE == 3'h0 && $past(PHASE) == 3'h0 |-> CURRENT_REF == 16'h0000)
        else $error("zero phase with nonzero reference");
    // Read data only in the cycle after a read
    read_idle_a: assert property (!$past(RD) |-> RDATA == 16'h0000)
        else $error("read data outside read slot");
endmodule // lms_chk

bind lms_top lms_chk #(.MS_CYCLES(MS_CYCLES)) chk_i (.REF_CLK(REF_CLK), .RST(RST), .RD(RD), .RDATA(RDATA),
    .LIFT_CMD(LIFT_CMD), .DROP_CMD(DROP_CMD), .FAULT_COND(FAULT_COND), .CURRENT_REF(CURRENT_REF),
    .PHASE(PHASE), .FAULT_ACTIVE(FAULT_ACTIVE));

// *** dv/lms_reg_model.sv ***
`timescale 1ns/10ps
// ********************
// Current regulator model
// ********************
module lms_reg_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic [15:0] cref,
    output logic [15:0] fb
);
    // Slow mode slews 0.1% a cycle, so agreement is not instant
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            fb <= 16'h0000;
        end else if (!slow || fb == cref) begin
            fb <= cref;
        end else if ($signed(fb) < $signed(cref)) begin
            fb <= fb + 16'h0001;
        end else begin
            fb <= fb - 16'h0001;
        end
    end
endmodule // lms_reg_model

// *** dv/lms_tb_top.sv ***
`timescale 1ns/10ps
`include "lms_defines.vh"
// ********************
// Sequencer testbench
// ********************
module lms_tb_top;
    localparam int MSC = 2;
    localparam int TMO = 2 * 100 * MSC; // two 0.1 s units
    logic clk, rst, wr, rd, lift, drop, freset, slow, exp;
    logic [7:0] addr;
    logic [15:0] wdata, rdata, cond, fb, cref, v;
    logic [2:0] phase;
    logic factive;
    int mismatches, total_checks, n, att, b;
    int ord[10] = '{0, 2, 4, 5, 8, 9, 1, 3, 6, 7};
    logic [7:0] ra[10] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h20};
    logic [15:0] rv[10] = '{16'h0084, 16'h0003, 16'h03e8, 16'h02ee, 16'hff9c, 16'h0096, 16'h0096,
        16'h0014, 16'h0008, 16'h0000};
    logic [7:0] sa[7] = '{8'h07, 8'h09, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08};
    logic [15:0] sv[7] = '{16'h0002, 16'h0002, 16'h0064, 16'h0014, 16'h000a, 16'h000f, 16'h01f4};

    lms_top #(.MS_CYCLES(MSC)) DUT (.REF_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .LIFT_CMD(lift), .DROP_CMD(drop), .FAULT_RESET(freset), .FAULT_COND(cond),
        .CURRENT_FB(fb), .CURRENT_REF(cref), .PHASE(phase), .FAULT_ACTIVE(factive));
    lms_reg_model regm (.clk(clk), .rst(rst), .slow(slow), .cref(cref), .fb(fb));

    // Clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] expv);
        total_checks++;
        if (seen !== expv) begin
            mismatches++;
            $display("FAIL at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask

    task automatic cycles(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    // Bounded wait for a phase, n counts the cycles spent
    task automatic wait_ph(input logic [2:0] p, input int lim);
        n = 0;
        while (phase !== p && n < lim) begin
            cycles(1);
            n++;
        end
        chk({13'h0000, phase}, {13'h0000, p});
    endtask

    // Pin reset pulse, driven on edges like every other input
    task automatic pulse_reset();
        @(posedge clk);
        freset <= 1'b1;
        @(posedge clk);
        freset <= 1'b0;
        cycles(3);
        att = 0;
    endtask

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Watchdog, several times the expected run
    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        test_done();
    end

    // Main sequence
    initial begin
        rst = 1'b1;
        {wr, rd, lift, drop, freset, slow} = 6'b000001;
        addr = 8'h00;
        wdata = 16'h0000;
        cond = 16'h0000;
        mismatches = 0;
        total_checks = 0;
        att = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            rd_reg(ra[i], v);
            chk(v, rv[i]);
        end
        wr_reg(`LMS_ADDR_MASK, 16'h00ca);
        rd_reg(`LMS_ADDR_MASK, v);
        chk(v, 16'h00ca);
        for (int i = 0; i < 7; i++) wr_reg(sa[i], sv[i]);
        $display("Test registers done");
        // Lift mode cycle
        wr_reg(`LMS_ADDR_CTRL, 16'h0000);
        @(posedge clk) lift <= 1'b1;
        wait_ph(3'h1, 8);
        chk(cref, 16'h0064);
        wait_ph(3'h2, 1000);
        chk(16'(n >= TMO - 10), 16'h0001);
        chk(cref, 16'h0014);
        @(posedge clk) lift <= 1'b0;
        wait_ph(3'h4, 8);
        chk(cref, 16'h000f);
        wait_ph(3'h0, 1000);
        chk(16'(n >= TMO - 10 && n <= TMO + 10), 16'h0001);
        $display("Test lift mode done");
        // Lift-Drop: drop released early, then clean timer
        wr_reg(`LMS_ADDR_CTRL, 16'h0001);
        for (int k = 0; k < 2; k++) begin
            @(posedge clk) lift <= 1'b1;
            wait_ph(3'h1, 8);
            wait_ph(3'h2, 1000);
            @(posedge clk) lift <= 1'b0;
            wait_ph(3'h3, 8);
            cycles(100);
            chk(cref, 16'h000a);
            @(posedge clk) drop <= 1'b1;
            wait_ph(3'h4, 8);
            chk(cref, 16'h000f);
            if (k == 0) begin
                cycles(20);
                @(posedge clk) drop <= 1'b0;
                wait_ph(3'h0, 8);
            end else begin
                wait_ph(3'h0, 1000);
                chk(16'(n >= TMO - 10 && n <= TMO + 10), 16'h0001);
                @(posedge clk) drop <= 1'b0;
            end
        end
        $display("Test lift-drop mode done");
        // Fault in hold, then lift refused while latched
        wr_reg(`LMS_ADDR_CTRL, 16'h0000);
        @(posedge clk) lift <= 1'b1;
        wait_ph(3'h2, 1000);
        @(posedge clk) cond <= 16'h0010;
        wait_ph(3'h0, 8);
        cycles(3);
        chk(cref, 16'h0000);
        @(posedge clk) cond <= 16'h0000;
        cycles(10);
        chk({13'h0000, phase}, 16'h0000);
        rd_reg(`LMS_ADDR_FAULTS, v);
        chk(v, 16'h0010);
        rd_reg(`LMS_ADDR_STATUS, v);
        chk(v, 16'h0008);
        // Lift dropped first, else the cleared fault restarts a lift
        @(posedge clk) lift <= 1'b0;
        wr_reg(`LMS_ADDR_CTRL, 16'h0002);
        cycles(3);
        chk({15'h0000, factive}, 16'h0000);
        // Each fault bit, masked auto reset and attempt limit
        for (int i = 0; i < 11; i++) begin
            b = (i < 10) ? ord[i] : 10;
            @(posedge clk) cond[b] <= 1'b1;
            cycles(4);
            chk({15'h0000, factive}, {15'h0000, b < 10});
            @(posedge clk) cond[b] <= 1'b0;
            cycles(5);
            exp = b < 10 && !((16'h00ca >> b & 1) && att < `LMS_LIMIT_RST);
            chk({15'h0000, factive}, {15'h0000, exp});
            if (exp) pulse_reset();
            else if (b < 10) att++;
        end
        $display("Test faults done");
        test_done();
    end
endmodule // lms_tb_top

// *** inc/lms_defines.vh ***
`ifndef LMS_DEFINES_VH
`define LMS_DEFINES_VH

// ****************************************
// Register offsets (word index on ADDR)
// ****************************************
`define LMS_ADDR_CTRL 8'h00
`define LMS_ADDR_MASK 8'h01
`define LMS_ADDR_LIMIT 8'h02
`define LMS_ADDR_LIFT_LVL 8'h03
`define LMS_ADDR_HOLD_LVL 8'h04
`define LMS_ADDR_DRIB_LVL 8'h05
`define LMS_ADDR_CLEAN_LVL 8'h06
`define LMS_ADDR_LIFT_TIME 8'h07
`define LMS_ADDR_DRIB_RATE 8'h08
`define LMS_ADDR_CLEAN_TIME 8'h09
`define LMS_ADDR_STATUS 8'h0a
`define LMS_ADDR_FAULTS 8'h0b
`define LMS_ADDR_REF 8'h0c

// ****************************************
// Field positions and reset values
// ****************************************
`define LMS_CTRL_MODE 0
`define LMS_CTRL_FRESET 1
`define LMS_MASK_RST 16'h0084
`define LMS_LIMIT_RST 4'h3
`define LMS_LIFT_LVL_RST 16'h03e8
`define LMS_HOLD_LVL_RST 16'h02ee
`define LMS_DRIB_LVL_RST 16'hff9c
`define LMS_CLEAN_LVL_RST 16'h0096
`define LMS_LIFT_TIME_RST 16'h0096
`define LMS_DRIB_RATE_RST 16'h0014
`define LMS_CLEAN_TIME_RST 16'h0008
`define LMS_AGREE 17'h0000a
`define LMS_FAULT_USED 16'h03ff

// ****************************************
// Timing
// ****************************************
`define LMS_CLK_PERIOD_NS 4
`define LMS_MS_NS 1000000
`define LMS_MS_CYCLES (`LMS_MS_NS / `LMS_CLK_PERIOD_NS)
`define LMS_MS_PER_UNIT 7'h64
`define LMS_RAMP_STEP 16'h03e8

`endif

// *** src/lms_fault.v ***
`timescale 1ns/10ps
`include "lms_defines.vh"
// ****************************************
// Fault latches with masked auto reset
// ****************************************
module lms_fault (
    input wire clk,
    input wire rst,
    input wire [15:0] cond,
    input wire [15:0] mask,
    input wire [3:0] limit,
    input wire ext_reset,
    output reg [15:0] latched,
    output reg [3:0] used
);
    wire [15:0] auto_clr;
    wire can_auto;
    wire [15:0] fault_used;

    // Auto resets stop once the attempt budget is spent
    assign can_auto = (used < limit);
    // Bits that carry a real fault; the rest never latch
    assign fault_used = `LMS_FAULT_USED;

    genvar i;
    generate
        for (i = 0; i < 16; i = i + 1) begin : g_bit
            // Clear only when masked and condition gone
            assign auto_clr[i] = latched[i] & mask[i] & ~cond[i] & can_auto; // [RULE1]
            // Present condition always wins over any clear
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    latched[i] <= 1'b0;
                end else if (cond[i] & fault_used[i]) begin
                    latched[i] <= 1'b1;
                end else if (auto_clr[i] | ext_reset) begin
                    latched[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // One attempt spent per cycle with any auto clear
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            used <= 4'h0;
        end else if (ext_reset) begin
            used <= 4'h0;
        end else if (|auto_clr) begin
            used <= used + 4'h1; // [RULE13]
        end
    end
endmodule // lms_fault

// *** src/lms_timer.v ***
`timescale 1ns/10ps
`include "lms_defines.vh"
// ****************************************
// Phase timer counting 0.1 s units
// ****************************************
module lms_timer #(
    parameter W = 16
) (
    input wire clk,
    input wire rst,
    input wire start,
    input wire [W-1:0] units,
    input wire ms_tick,
    output reg done
);
    reg [W+6:0] count;
    reg [W+6:0] target;

    // Restart on start, flag done once target ms counted
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= {(W+7){1'b0}};
            target <= {(W+7){1'b0}};
            done <= 1'b0;
        end else if (start) begin
            count <= {(W+7){1'b0}};
            // Both operands at full width so the product cannot wrap
            target <= {7'h00, units} * {{W{1'b0}}, `LMS_MS_PER_UNIT};
            done <= 1'b0;
        end else if (count >= target) begin
            done <= 1'b1;
        end else if (ms_tick) begin
            count <= count + 1'b1;
        end
    end
endmodule // lms_timer

// *** src/lms_top.v ***
`timescale 1ns/10ps
`include "lms_defines.vh"
// Summary of operation
// [RULE1] Latched fault auto-clears only if mask bit set and its condition gone.
// [RULE2] Mask bit 1 is bus undervoltage, bit 3 excess bus voltage.
// [RULE3] Mask bit 6 is magnet overheat, bit 7 ambient overheat.
// [RULE4] Mask is four hex digits; lowest digit holds bits 0 to 3.
// [RULE5] Lift phase drives lift level; hold after level reached and lift timer done.
// [RULE6] Hold phase drives the hold current level.
// [RULE7] Lift-Drop: lift removed ramps down at dribble rate to dribble level.
// [RULE8] Drop phase drives the clean current level.
// [RULE9] Lift mode: drop phase ends in zero phase when lift timer expires.
// [RULE10] Lift-Drop: drop ends on clean timer expiry or drop removed.
// [RULE11] Lift mode: removing lift command enters the drop phase.
// [RULE12] Lift-Drop mode: asserting drop command enters the drop phase.
// [RULE13] Auto resets limited to a set count, default 3; then external reset.
// [RULE14] Any active fault forces the current reference to zero.
// [RULE15] Other mask bits: 0,2,4,5,8,9 as listed; bits 10 to 15 ignored.
// [RULE16] Start in zero phase; lift command with no fault enters lift.
module lms_top #(
    parameter MS_CYCLES = `LMS_MS_CYCLES
) (
    input wire REF_CLK,
    input wire RST,
    input wire [7:0] ADDR,
    input wire [15:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [15:0] RDATA,
    input wire LIFT_CMD,
    input wire DROP_CMD,
    input wire FAULT_RESET,
    input wire [15:0] FAULT_COND,
    input wire [15:0] CURRENT_FB,
    output reg [15:0] CURRENT_REF,
    output reg [2:0] PHASE,
    output reg FAULT_ACTIVE
);
    // ****************************************
    // Phase encodings
    // ****************************************
    localparam ST_ZERO = 3'h0;
    localparam ST_LIFT = 3'h1;
    localparam ST_HOLD = 3'h2;
    localparam ST_DRIB = 3'h3;
    localparam ST_DROP = 3'h4;

    // ****************************************
    // Configuration registers
    // ****************************************
    reg mode;
    reg [15:0] fault_autoreset_mask;
    reg [3:0] autoreset_attempt_limit;
    reg signed [15:0] lift_current_level;
    reg signed [15:0] hold_current_level;
    reg signed [15:0] dribble_current_level;
    reg signed [15:0] clean_current_level;
    reg [15:0] lift_timer;
    reg [15:0] dribble_rate;
    reg [15:0] clean_timer;
    reg sw_reset;

    // ****************************************
    // Internal state
    // ****************************************
    reg [2:0] state;
    reg [2:0] next_state;
    reg [31:0] ms_count;
    reg ms_tick;
    reg signed [15:0] ramp;
    reg [15:0] ramp_acc;
    reg [15:0] timer_units;
    wire timer_start;
    wire timer_done;
    wire [15:0] latched;
    wire [3:0] used;
    wire any_fault;
    wire fault_reset;
    wire [16:0] diff;
    wire [16:0] diff_mag;
    wire reached;
    wire wr_hit;

    assign fault_reset = sw_reset | FAULT_RESET;
    assign any_fault = |latched;
    assign wr_hit = WR;

    // ****************************************
    // Register writes
    // ****************************************
    // Reset pulse self-clears so software need not undo it
    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            mode <= 1'b0;
            fault_autoreset_mask <= `LMS_MASK_RST;
            autoreset_attempt_limit <= `LMS_LIMIT_RST;
            lift_current_level <= `LMS_LIFT_LVL_RST;
            hold_current_level <= `LMS_HOLD_LVL_RST;
            dribble_current_level <= `LMS_DRIB_LVL_RST;
            clean_current_level <= `LMS_CLEAN_LVL_RST;
            lift_timer <= `LMS_LIFT_TIME_RST;
            dribble_rate <= `LMS_DRIB_RATE_RST;
            clean_timer <= `LMS_CLEAN_TIME_RST;
            sw_reset <= 1'b0;
        end else begin
            sw_reset <= 1'b0;
            if (wr_hit) begin
                case (ADDR)
                    `LMS_ADDR_CTRL: begin
                        mode <= WDATA[`LMS_CTRL_MODE];
                        sw_reset <= WDATA[`LMS_CTRL_FRESET];
                    end
                    `LMS_ADDR_MASK: begin
                        // Stored as entered, digit 1 in bits 3:0
                        fault_autoreset_mask <= WDATA; // [RULE4]
                    end
                    `LMS_ADDR_LIMIT: begin
                        autoreset_attempt_limit <= WDATA[3:0]; // [RULE13]
                    end
                    `LMS_ADDR_LIFT_LVL: begin
                        lift_current_level <= WDATA;
                    end
                    `LMS_ADDR_HOLD_LVL: begin
                        hold_current_level <= WDATA;
                    end
                    `LMS_ADDR_DRIB_LVL: begin
                        dribble_current_level <= WDATA;
                    end
                    `LMS_ADDR_CLEAN_LVL: begin
                        clean_current_level <= WDATA;
                    end
                    `LMS_ADDR_LIFT_TIME: begin
                        lift_timer <= WDATA;
                    end
                    `LMS_ADDR_DRIB_RATE: begin
                        dribble_rate <= WDATA;
                    end
                    `LMS_ADDR_CLEAN_TIME: begin
                        clean_timer <= WDATA;
                    end
                    default: begin
                        sw_reset <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ****************************************
    // Register reads
    // ****************************************
    // Data stand one cycle after RD; unmapped reads give zero
    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            RDATA <= 16'h0000;
        end else if (RD) begin
            case (ADDR)
                `LMS_ADDR_CTRL: RDATA <= {15'h0000, mode};
                `LMS_ADDR_MASK: RDATA <= fault_autoreset_mask; // [RULE4]
                `LMS_ADDR_LIMIT: RDATA <= {12'h000, autoreset_attempt_limit};
                `LMS_ADDR_LIFT_LVL: RDATA <= lift_current_level;
                `LMS_ADDR_HOLD_LVL: RDATA <= hold_current_level;
                `LMS_ADDR_DRIB_LVL: RDATA <= dribble_current_level;
                `LMS_ADDR_CLEAN_LVL: RDATA <= clean_current_level;
                `LMS_ADDR_LIFT_TIME: RDATA <= lift_timer;
                `LMS_ADDR_DRIB_RATE: RDATA <= dribble_rate;
                `LMS_ADDR_CLEAN_TIME: RDATA <= clean_timer;
                `LMS_ADDR_STATUS: RDATA <= {4'h0, used, 4'h0, any_fault, state};
                `LMS_ADDR_FAULTS: RDATA <= latched;
                `LMS_ADDR_REF: RDATA <= CURRENT_REF;
                default: RDATA <= 16'h0000;
            endcase
        end else begin
            RDATA <= 16'h0000;
        end
    end

    // ****************************************
    // Millisecond tick
    // ****************************************
    // Shared base for phase timers and dribble ramp
    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            ms_count <= 32'h00000000;
            ms_tick <= 1'b0;
        end else if (ms_count >= MS_CYCLES - 1) begin
            ms_count <= 32'h00000000;
            ms_tick <= 1'b1;
        end else begin
            ms_count <= ms_count + 32'h00000001;
            ms_tick <= 1'b0;
        end
    end

    // ****************************************
    // Faults
    // ****************************************
    // Bit map: 0 supply low, 1 bus under, 2 heatsink, 3 bus over,
    // 4 external, 5 minor external, 6 magnet hot, 7 ambient hot,
    // 8 ground leak, 9 open circuit; 10 to 15 never latch
    lms_fault u_fault ( // [RULE2] [RULE3] [RULE15]
        .clk(REF_CLK),
        .rst(RST),
        .cond(FAULT_COND),
        .mask(fault_autoreset_mask),
        .limit(autoreset_attempt_limit),
        .ext_reset(fault_reset),
        .latched(latched),
        .used(used)
    );

    // ****************************************
    // Lift level agreement
    // ****************************************
    // Feedback within a small window of the lift level
    assign diff = {CURRENT_FB[15], CURRENT_FB} - {lift_current_level[15], lift_current_level};
    assign diff_mag = diff[16] ? (17'h00000 - diff) : diff;
    assign reached = (diff_mag <= `LMS_AGREE);

    // ****************************************
    // Phase timer
    // ****************************************
    // Reloaded on every phase change; only lift and drop read it
    assign timer_start = (next_state != state);

    // Drop in Lift mode reuses the lift time
    always @* begin
        timer_units = lift_timer;
        if (next_state == ST_DROP && mode) begin
            timer_units = clean_timer;
        end
    end

    lms_timer #(
        .W(16)
    ) u_timer (
        .clk(REF_CLK),
        .rst(RST),
        .start(timer_start),
        .units(timer_units),
        .ms_tick(ms_tick),
        .done(timer_done)
    );

    // ****************************************
    // Phase sequencing
    // ****************************************
    // Mode 0 is Lift, mode 1 is Lift-Drop
    always @* begin
        next_state = state;
        if (any_fault) begin
            next_state = ST_ZERO; // [RULE14]
        end else begin
            case (state)
                ST_ZERO: begin
                    if (LIFT_CMD) begin
                        next_state = ST_LIFT; // [RULE16]
                    end
                end
                ST_LIFT: begin
                    if (!LIFT_CMD) begin
                        next_state = mode ? ST_DRIB : ST_DROP; // [RULE11] [RULE7]
                    end else if (reached && timer_done) begin
                        next_state = ST_HOLD; // [RULE5]
                    end
                end
                ST_HOLD: begin
                    if (!LIFT_CMD) begin
                        next_state = mode ? ST_DRIB : ST_DROP; // [RULE11] [RULE7]
                    end
                end
                ST_DRIB: begin
                    // Drop wins over a renewed lift
                    if (DROP_CMD) begin
                        next_state = ST_DROP; // [RULE12]
                    end else if (LIFT_CMD) begin
                        next_state = ST_LIFT;
                    end
                end
                ST_DROP: begin
                    if (mode) begin
                        if (timer_done || !DROP_CMD) begin
                            next_state = ST_ZERO; // [RULE10]
                        end
                    end else if (timer_done) begin
                        next_state = ST_ZERO; // [RULE9]
                    end
                end
                default: begin
                    next_state = ST_ZERO;
                end
            endcase
        end
    end

    // Phase register
    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            state <= ST_ZERO; // [RULE16]
        end else begin
            state <= next_state;
        end
    end

    // ****************************************
    // Dribble ramp
    // ****************************************
    // Rate in 0.1%/s added per ms; one 0.1% step per 1000
    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            ramp <= 16'h0000;
            ramp_acc <= 16'h0000;
        end else if (state != ST_DRIB) begin
            ramp <= hold_current_level;
            ramp_acc <= 16'h0000;
        end else if (ms_tick) begin
            if (ramp_acc + dribble_rate >= `LMS_RAMP_STEP) begin
                ramp_acc <= ramp_acc + dribble_rate - `LMS_RAMP_STEP;
                // Stops at the dribble level, never below it
                if (ramp > dribble_current_level) begin
                    ramp <= ramp - 16'sh0001; // [RULE7]
                end
            end else begin
                ramp_acc <= ramp_acc + dribble_rate;
            end
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Reference per phase; fault overrides all
    always @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            CURRENT_REF <= 16'h0000;
            PHASE <= ST_ZERO;
            FAULT_ACTIVE <= 1'b0;
        end else begin
            PHASE <= state;
            FAULT_ACTIVE <= any_fault;
            if (any_fault) begin
                CURRENT_REF <= 16'h0000; // [RULE14]
            end else begin
                case (state)
                    ST_LIFT: CURRENT_REF <= lift_current_level; // [RULE5]
                    ST_HOLD: CURRENT_REF <= hold_current_level; // [RULE6]
                    ST_DRIB: CURRENT_REF <= ramp; // [RULE7]
                    ST_DROP: CURRENT_REF <= clean_current_level; // [RULE8]
                    default: CURRENT_REF <= 16'h0000;
                endcase
            end
        end
    end
endmodule // lms_top
